// ---- hw/tap_cfg.svh ----
`ifndef TAP_CFG_SVH
`define TAP_CFG_SVH

// ----------------------------------------------------------------
// boundary ring layout
// ----------------------------------------------------------------
`define BSR_LEN 109
`define OE_CELL 108
`define OE_CELL_RST 1'h1

// ----------------------------------------------------------------
// instruction codes and capture pattern
// ----------------------------------------------------------------
`define OP_EXTEST 3'h0
`define OP_IDCODE 3'h1
`define OP_SAMPZ 3'h2
`define OP_SAMPLE 3'h4
`define OP_BYPASS 3'h7
`define IR_CAPTURE 3'h1
// value is arbitrary, only the lsb of one is fixed
`define ID_CODE 32'h0ABC_D001

// ----------------------------------------------------------------
// link timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define TCK_PERIOD_NS 80
`define TCK_HALF ((`TCK_PERIOD_NS / `CLK_PERIOD_NS) / 2)

// ----------------------------------------------------------------
// controller register map
// ----------------------------------------------------------------
`define CTRL_ADDR 8'h00
`define TMS_ADDR 8'h04
`define TDI_ADDR 8'h08
`define TDO_ADDR 8'h0C
`define STATUS_ADDR 8'h10
`define CTRL_LEN_MSB 5
`define CTRL_RST_BIT 8
`define MAX_LEN 6'h20
`define RST_TMS 32'h0000_001F
`define RST_LEN 6'h05

`endif

// ---- hw/tap_pkg.sv ----
package tap_pkg;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TLR = 4'h0,
    RTI = 4'h1,
    SEL_DR = 4'h2,
    CAP_DR = 4'h3,
    SHIFT_DR = 4'h4,
    EXIT1_DR = 4'h5,
    PAUSE_DR = 4'h6,
    EXIT2_DR = 4'h7,
    UPD_DR = 4'h8,
    SEL_IR = 4'h9,
    CAP_IR = 4'hA,
    SHIFT_IR = 4'hB,
    EXIT1_IR = 4'hC,
    PAUSE_IR = 4'hD,
    EXIT2_IR = 4'hE,
    UPD_IR = 4'hF
  } tap_state_t;

  typedef enum logic [1:0] {
    DR_BSR = 2'h0,
    DR_ID = 2'h1,
    DR_BYP = 2'h2
  } dr_sel_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_LOW = 2'h1,
    PH_HIGH = 2'h2
  } host_phase_t;

endpackage : tap_pkg

// ---- hw/jtag_if.sv ----
interface jtag_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;

  modport dev (
    input tck,
    input tms,
    input tdi,
    output tdo,
    output tdo_oe
  );

  modport ctl (
    output tck,
    output tms,
    output tdi,
    input tdo,
    input tdo_oe
  );
endinterface : jtag_if

// ---- hw/tap_device.sv ----
// The register addresses and the plain strobed port were decided locally.
`include "tap_cfg.svh"

module tap_device #(
  parameter int BSR_LEN = `BSR_LEN,
  parameter int OE_CELL = `OE_CELL,
  parameter logic [2:0] OP_EXTEST = `OP_EXTEST,
  parameter logic [2:0] OP_IDCODE = `OP_IDCODE,
  parameter logic [2:0] OP_SAMPZ = `OP_SAMPZ,
  parameter logic [2:0] OP_SAMPLE = `OP_SAMPLE,
  parameter logic [2:0] OP_BYPASS = `OP_BYPASS,
  parameter logic [31:0] ID_CODE = `ID_CODE
) (
  input wire logic core_clk,
  input wire logic rst_n,
  jtag_if.dev link,
  input wire logic [BSR_LEN-1:0] pin_ring,
  output logic [BSR_LEN-1:0] ring_drive,
  output logic extest_active,
  output logic q_bus_oe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    // the ring moves on the memory clock, so capture only reads stage two
    logic [BSR_LEN-1:0] pin_s1;
    logic [BSR_LEN-1:0] pin_s2;
    tap_pkg::tap_state_t st;
    logic [2:0] ir;
    logic [2:0] ir_sh;
    logic byp;
    logic [31:0] id_sh;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_upd;
    logic tdo;
    logic tdo_oe;
  } dev_st_t;

  dev_st_t r;
  dev_st_t next_r;
  logic rise;
  logic fall;
  logic tms;
  logic tdi;
  tap_pkg::dr_sel_t sel;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic tap_pkg::tap_state_t tap_next(input tap_pkg::tap_state_t s,
                                                    input logic m);
    tap_pkg::tap_state_t n;
    n = s;
    unique case (s)
      tap_pkg::TLR: n = m ? tap_pkg::TLR : tap_pkg::RTI;
      tap_pkg::RTI: n = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_DR: n = m ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
      tap_pkg::CAP_DR: n = m ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      tap_pkg::SHIFT_DR: n = m ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      tap_pkg::EXIT1_DR: n = m ? tap_pkg::UPD_DR : tap_pkg::PAUSE_DR;
      tap_pkg::PAUSE_DR: n = m ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
      tap_pkg::EXIT2_DR: n = m ? tap_pkg::UPD_DR : tap_pkg::SHIFT_DR;
      tap_pkg::UPD_DR: n = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_IR: n = m ? tap_pkg::TLR : tap_pkg::CAP_IR;
      tap_pkg::CAP_IR: n = m ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      tap_pkg::SHIFT_IR: n = m ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      tap_pkg::EXIT1_IR: n = m ? tap_pkg::UPD_IR : tap_pkg::PAUSE_IR;
      tap_pkg::PAUSE_IR: n = m ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
      tap_pkg::EXIT2_IR: n = m ? tap_pkg::UPD_IR : tap_pkg::SHIFT_IR;
      tap_pkg::UPD_IR: n = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
    endcase
    return n;
  endfunction : tap_next

  // reserved codes fall back to bypass so the path is never open
  function automatic tap_pkg::dr_sel_t dr_select(input logic [2:0] op);
    tap_pkg::dr_sel_t d;
    d = tap_pkg::DR_BYP;
    if (op == OP_EXTEST || op == OP_SAMPLE || op == OP_SAMPZ) begin
      d = tap_pkg::DR_BSR;
    end else if (op == OP_IDCODE) begin
      d = tap_pkg::DR_ID;
    end
    return d;
  endfunction : dr_select

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    // tck is only sampled here; metastable first stages feed only stage two
    next_r.tck_s = {r.tck_s[1:0], link.tck};
    next_r.tms_s = {r.tms_s[0], link.tms};
    next_r.tdi_s = {r.tdi_s[0], link.tdi};
    next_r.pin_s1 = pin_ring;
    next_r.pin_s2 = r.pin_s1;
    rise = r.tck_s[1] & ~r.tck_s[2];
    fall = ~r.tck_s[1] & r.tck_s[2];
    tms = r.tms_s[1];
    tdi = r.tdi_s[1];
    sel = dr_select(r.ir);
    if (rise) begin
      case (r.st)
        tap_pkg::CAP_DR: begin
          case (sel)
            tap_pkg::DR_BSR: next_r.bsr_sh = r.pin_s2;
            tap_pkg::DR_ID: next_r.id_sh = ID_CODE;
            default: next_r.byp = 1'h0;
          endcase
        end
        tap_pkg::SHIFT_DR: begin
          case (sel)
            tap_pkg::DR_BSR: next_r.bsr_sh = {tdi, r.bsr_sh[BSR_LEN-1:1]};
            tap_pkg::DR_ID: next_r.id_sh = {tdi, r.id_sh[31:1]};
            default: next_r.byp = tdi;
          endcase
        end
        tap_pkg::UPD_DR: begin
          if (sel == tap_pkg::DR_BSR) begin
            next_r.bsr_upd = r.bsr_sh;
          end
        end
        tap_pkg::CAP_IR: next_r.ir_sh = `IR_CAPTURE;
        tap_pkg::SHIFT_IR: next_r.ir_sh = {tdi, r.ir_sh[2:1]};
        tap_pkg::UPD_IR: next_r.ir = r.ir_sh;
        default: begin
        end
      endcase
      // five tms highs reach TLR from any state through the graph
      next_r.st = tap_next(r.st, tms);
      // reload on entry, so a five-high reset takes hold at its own edge
      if (next_r.st == tap_pkg::TLR) begin
        next_r.ir = OP_IDCODE;
        next_r.bsr_upd[OE_CELL] = `OE_CELL_RST;
      end
    end
    if (fall) begin
      next_r.tdo_oe = (r.st == tap_pkg::SHIFT_DR) || (r.st == tap_pkg::SHIFT_IR);
      if (r.st == tap_pkg::SHIFT_IR) begin
        next_r.tdo = r.ir_sh[0];
      end else begin
        case (sel)
          tap_pkg::DR_BSR: next_r.tdo = r.bsr_sh[0];
          tap_pkg::DR_ID: next_r.tdo = r.id_sh[0];
          default: next_r.tdo = r.byp;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      // undriven mode select and data in read high, as the pulled-up pins do
      r.tms_s <= 2'h3;
      r.tdi_s <= 2'h3;
      r.st <= tap_pkg::TLR;
      r.ir <= OP_IDCODE;
      r.bsr_upd[OE_CELL] <= `OE_CELL_RST;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // memory side only sees these gates; a test reset touches nothing else
  assign link.tdo = r.tdo;
  assign link.tdo_oe = r.tdo_oe;
  assign ring_drive = r.bsr_upd;
  assign extest_active = (r.ir == OP_EXTEST);
  assign q_bus_oe = (r.ir == OP_SAMPZ) ? 1'h0 :
                    (r.ir == OP_EXTEST) ? r.bsr_upd[OE_CELL] : 1'h1;

endmodule : tap_device

// ---- hw/tap_ctl.sv ----
`include "tap_cfg.svh"

module tap_ctl #(
  parameter int TCK_HALF = `TCK_HALF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  jtag_if.ctl link,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    tap_pkg::host_phase_t ph;
    logic [7:0] cnt;
    logic [5:0] len;
    logic [5:0] idx;
    logic [31:0] tms_v;
    logic [31:0] tdi_v;
    logic [31:0] tdo_v;
    logic [1:0] tdo_s;
    logic tck;
    logic tms;
    logic tdi;
    logic [31:0] rdata;
  } ctl_st_t;

  localparam logic [7:0] HALF_M1 = 8'(TCK_HALF - 1);

  ctl_st_t r;
  ctl_st_t next_r;
  logic idle;
  logic [5:0] wlen;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.tdo_s = {r.tdo_s[0], link.tdo};
    idle = (r.ph == tap_pkg::PH_IDLE);
    wlen = wdata[`CTRL_LEN_MSB:0];
    next_r.rdata = 32'h0000_0000;
    if (rd) begin
      case (addr)
        `TMS_ADDR: next_r.rdata = r.tms_v;
        `TDI_ADDR: next_r.rdata = r.tdi_v;
        `TDO_ADDR: next_r.rdata = r.tdo_v;
        `STATUS_ADDR: next_r.rdata = {31'h0000_0000, ~idle};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
    // writes while a scan runs are dropped so the vectors stay coherent
    if (wr && idle) begin
      case (addr)
        `TMS_ADDR: next_r.tms_v = wdata;
        `TDI_ADDR: next_r.tdi_v = wdata;
        `CTRL_ADDR: begin
          if (wdata[`CTRL_RST_BIT]) begin
            next_r.tms_v = `RST_TMS;
            next_r.len = `RST_LEN;
            next_r.tdo_v = 32'h0000_0000;
            next_r.idx = 6'h00;
            next_r.tms = 1'h1;
            next_r.ph = tap_pkg::PH_LOW;
            next_r.cnt = HALF_M1;
          end else if (wlen != 6'h00 && wlen <= `MAX_LEN) begin
            next_r.len = wlen;
            next_r.tdo_v = 32'h0000_0000;
            next_r.idx = 6'h00;
            next_r.tms = r.tms_v[0];
            next_r.tdi = r.tdi_v[0];
            next_r.ph = tap_pkg::PH_LOW;
            next_r.cnt = HALF_M1;
          end
        end
        default: begin
        end
      endcase
    end
    case (r.ph)
      tap_pkg::PH_LOW: begin
        if (r.cnt == 8'h00) begin
          next_r.tck = 1'h1;
          next_r.cnt = HALF_M1;
          next_r.ph = tap_pkg::PH_HIGH;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      tap_pkg::PH_HIGH: begin
        if (r.cnt == 8'h00) begin
          // tdo settled after the last fall plus both sync stages
          next_r.tdo_v[r.idx[4:0]] = r.tdo_s[1];
          next_r.tck = 1'h0;
          if (r.idx == r.len - 6'h01) begin
            next_r.ph = tap_pkg::PH_IDLE;
          end else begin
            next_r.idx = r.idx + 6'h01;
            next_r.tms = r.tms_v[5'(r.idx + 6'h01)];
            next_r.tdi = r.tdi_v[5'(r.idx + 6'h01)];
            next_r.cnt = HALF_M1;
            next_r.ph = tap_pkg::PH_LOW;
          end
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.tms <= 1'h1;
      r.tdi <= 1'h1;
    end else begin
      r <= next_r;
    end
  end

  assign link.tck = r.tck;
  assign link.tms = r.tms;
  assign link.tdi = r.tdi;
  assign rdata = r.rdata;

endmodule : tap_ctl

// ---- dv/tap_link_checker.sv ----
module tap_link_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // reference controller, stepped on every tck rise seen here
  // ----------------------------------------------------------------
  // next state per current state, one nibble each, for tms low and high
  localparam logic [63:0] NEXT_LOW = 64'h1BDD_BBA1_4664_4311;
  localparam logic [63:0] NEXT_HIGH = 64'h2FEF_CC02_8785_5920;
  logic tck_q;
  logic [3:0] st;
  logic [3:0] pv;
  logic [2:0] hi;
  logic [3:0] nx;
  assign nx = tms ? NEXT_HIGH[{st, 2'h0} +: 4] : NEXT_LOW[{st, 2'h0} +: 4];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_q <= 1'b0;
      st <= 4'h0;
      pv <= 4'h0;
      hi <= 3'h0;
    end else begin
      tck_q <= tck;
      if (tck && !tck_q) begin
        pv <= st;
        st <= nx;
        // saturate so a long tms-high run cannot wrap back below five
        hi <= !tms ? 3'h0 : (hi == 3'h7) ? hi : hi + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_tdo_fall_edge: assert property ($changed(tdo) |-> !tck)
    else $error("tdo changed while tck high");
  chk_oe_fall_edge: assert property ($changed(tdo_oe) |-> !tck)
    else $error("tdo_oe changed while tck high");
  chk_tck_high_len: assert property ($rose(tck) |-> tck [*4] ##1 !tck)
    else $error("tck high phase not four cycles");
  chk_sample_stable: assert property ($rose(tck) |-> ($stable(tms) && $stable(tdi)) [*4])
    else $error("tms or tdi moved around tck rise");
  chk_oe_shift_only: assert property ($fell(tck) |-> ##4 (tdo_oe == (st == 4'h4 || st == 4'hB)))
    else $error("tdo_oe disagrees with shift state");
  chk_oe_power_up: assert property ($rose(rst_n) |-> !tdo_oe)
    else $error("tdo driven after reset");
  chk_ir_capture_lsb: assert property ($fell(tck) && st == 4'hB && pv == 4'hA |-> ##4 tdo)
    else $error("first instruction bit out is not one");
  chk_five_high_reset: assert property ($fell(tck) && hi >= 3'h5 |-> ##4 !tdo_oe)
    else $error("tdo driven after five tms highs");
endmodule : tap_link_checker

// ---- dv/test_sram_boundary_scan_tap.sv ----
`include "tap_cfg.svh"

module test_sram_boundary_scan_tap;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // signals and cases
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] len;
    logic [31:0] tms;
    logic [31:0] tdi;
    logic [31:0] mask;
    logic [31:0] exp;
  } row_t;
  // from reset: to shift-dr, read id, to idle, load bypass, bypass scan twice
  localparam row_t ROWS [6] = '{
    '{6'h04, 32'h2, 32'h0, 32'h0, 32'h0},
    '{6'h20, 32'h8000_0000, 32'h0, 32'hFFFF_FFFF, `ID_CODE},
    '{6'h02, 32'h1, 32'h0, 32'h0, 32'h0},
    '{6'h09, 32'hC3, {25'h0, `OP_BYPASS, 4'h0}, 32'h70, 32'h10},
    '{6'h0D, 32'hC01, 32'h528, 32'h7F8, 32'h250},
    '{6'h0D, 32'hC01, 32'h528, 32'h7F8, 32'h250}};
  localparam logic [108:0] P1 = {1'b1, {27{4'hA}}};
  localparam logic [108:0] P2 = {1'b0, {27{4'h5}}};
  localparam logic [108:0] P3 = {1'b1, {27{4'h9}}};
  localparam logic [108:0] D1 = {1'b0, {27{4'h3}}};
  localparam logic [108:0] D2 = {1'b1, {27{4'hC}}};
  logic core_clk;
  logic rst_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [108:0] pin_ring;
  logic [108:0] ring_drive;
  logic extest_active;
  logic q_bus_oe;
  logic [31:0] t;
  logic [108:0] o;
  int n_mismatch;
  int compares;

  jtag_if link ();
  tap_device u_tap_device (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .pin_ring(pin_ring), .ring_drive(ring_drive), .extest_active(extest_active),
    .q_bus_oe(q_bus_oe));
  tap_ctl u_tap_ctl (.core_clk(core_clk), .rst_n(rst_n), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  tap_link_checker u_tap_link_checker (.core_clk(core_clk), .rst_n(rst_n), .tck(link.tck),
    .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdo_oe(link.tdo_oe));

  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_ring(input string what, input logic [108:0] exp, input logic [108:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_ring

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // bounded poll: a stuck busy is counted by the busy compare and the scan goes on
  task automatic scan(input logic [5:0] n, input logic [31:0] tv, input logic [31:0] dv,
      output logic [31:0] q);
    logic [31:0] s;
    wr_reg(`TMS_ADDR, tv);
    wr_reg(`TDI_ADDR, dv);
    wr_reg(`CTRL_ADDR, {26'h0, n});
    s = 32'h1;
    for (int i = 0; i < 400 && s[0] !== 1'b0; i++) rd_reg(`STATUS_ADDR, s);
    cmp_bit("busy", 1'b0, s[0]);
    rd_reg(`TDO_ADDR, q);
  endtask : scan

  task automatic run_rows(input int first, input int last);
    for (int i = first; i <= last; i++) begin
      scan(ROWS[i].len, ROWS[i].tms, ROWS[i].tdi, t);
      cmp_word("row tdo", ROWS[i].exp, t & ROWS[i].mask);
    end
  endtask : run_rows

  task automatic ir_load(input logic [2:0] op);
    logic [31:0] v;
    scan(6'h09, 32'hC3, {25'h0, op, 4'h0}, v);
    cmp_word("ir capture", 32'h10, v & 32'h70);
  endtask : ir_load

  task automatic bsr_scan(input logic [108:0] pins, input logic [108:0] din,
      output logic [108:0] dout);
    logic [31:0] v;
    @(posedge core_clk);
    pin_ring <= pins;
    scan(6'h03, 32'h1, 32'h0, v);
    for (int k = 0; k < 3; k++) begin
      scan(6'h20, 32'h0, din[k*32 +: 32], v);
      dout[k*32 +: 32] = v;
    end
    scan(6'h0F, 32'h3000, {19'h0, din[108:96]}, v);
    dout[108:96] = v[12:0];
  endtask : bsr_scan

  task automatic reset_pulse();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    cmp_bit("tdo_oe", 1'b0, link.tdo_oe);
    cmp_ring("ring_drive", {1'b1, 108'h0}, ring_drive);
    cmp_bit("extest_active", 1'b0, extest_active);
  endtask : reset_pulse

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  // whole run is some 5000 cycles; the limit leaves ample margin
  initial begin
    #500000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    pin_ring = '0;
    n_mismatch = 0;
    compares = 0;
    reset_pulse();
    run_rows(0, 5);
    ir_load(`OP_SAMPLE);
    bsr_scan(P1, D1, o);
    cmp_ring("ring capture", P1, o);
    cmp_ring("ring_drive", D1, ring_drive);
    cmp_bit("q_bus_oe", 1'b1, q_bus_oe);
    ir_load(`OP_EXTEST);
    cmp_bit("extest_active", 1'b1, extest_active);
    cmp_bit("q_bus_oe", 1'b0, q_bus_oe);
    bsr_scan(P2, D2, o);
    cmp_ring("ring capture", P2, o);
    cmp_bit("q_bus_oe", 1'b1, q_bus_oe);
    ir_load(`OP_SAMPZ);
    cmp_bit("q_bus_oe", 1'b0, q_bus_oe);
    bsr_scan(P3, D1, o);
    cmp_ring("ring capture", P3, o);
    cmp_bit("q_bus_oe", 1'b0, q_bus_oe);
    scan(6'h05, 32'h1F, 32'h0, t);
    cmp_bit("q_bus_oe", 1'b1, q_bus_oe);
    cmp_bit("ring preset", 1'b1, ring_drive[108]);
    run_rows(0, 2);
    ir_load(`OP_EXTEST);
    wr_reg(`CTRL_ADDR, 32'h0000_0100);
    repeat (60) @(posedge core_clk);
    rd_reg(`STATUS_ADDR, t);
    cmp_word("status", 32'h0, t);
    cmp_bit("extest_active", 1'b0, extest_active);
    run_rows(0, 2);
    ir_load(`OP_EXTEST);
    reset_pulse();
    run_rows(0, 2);
    wr_reg(`CTRL_ADDR, 32'h0);
    rd_reg(`STATUS_ADDR, t);
    cmp_word("status", 32'h0, t);
    rd_reg(8'h20, t);
    cmp_word("unmapped", 32'h0, t);
    print_verdict();
  end
endmodule : test_sram_boundary_scan_tap
